// ===== shared/amo_pkg.sv
// shared constants and types for the alarm mask and offset register bank
`default_nettype none
package amo_pkg;
   // register addresses (byte addresses as printed)
   localparam logic [9:0] ADDR_ALARM_SUMMARY = 10'h2C0;
   localparam logic [9:0] ADDR_ALARM_STATUS  = 10'h2C1;
   localparam logic [9:0] ADDR_SOURCE_MASK   = 10'h2C2;
   localparam logic [9:0] ADDR_LANE_FAULT    = 10'h2C4;
   localparam logic [9:0] ADDR_CORE0_TRIM_LO = 10'h330;
   localparam logic [9:0] ADDR_CORE0_TRIM_HI = 10'h331;
   // alarm bit positions, shared by status and mask
   localparam int BIT_FIFO    = 5;
   localparam int BIT_SPLL    = 4;
   localparam int BIT_LINK    = 3;
   localparam int BIT_REALIGN = 2;
   localparam int BIT_CLKDIV  = 0;
   // reset values
   localparam logic [7:0]  MASK_RESET   = 8'h3F;
   localparam logic [7:0]  STATUS_RESET = 8'h3F;
   localparam logic [7:0]  LANE_RESET   = 8'hFF;
   localparam logic [15:0] TRIM_RESET   = 16'h0000;
   // implemented bits of the status register
   localparam logic [7:0]  STATUS_LIVE  = 8'h3D;
   // width of the offset field
   localparam int TRIM_W = 12;
   // register bus request
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } amo_req_s;
   // raw alarm events from the converter
   typedef struct packed {
      logic [7:0] lane_fifo_err;
      logic       serdes_unlock;
      logic       link_fault;
      logic       clk_realign;
      logic       div_mismatch;
   } amo_evt_s;
endpackage : amo_pkg
`default_nettype wire

// ===== rtl/amo_lane_flags.sv
// per-lane w1c fault flags with a clear-all input
`timescale 1ns/1ns
`default_nettype none
module amo_lane_flags #(
   parameter int LANES = 8
) (
   input  wire logic             ref_clk,   // system clock
   input  wire logic             resetn,    // async reset, active low
   input  wire logic [LANES-1:0] set_i,     // lane fault events
   input  wire logic [LANES-1:0] clr_i,     // write-one-to-clear mask
   input  wire logic             clr_all_i, // clear every lane
   output logic      [LANES-1:0] flags_o    // sticky lane flags
);
   // elaboration check: the register holds exactly eight lanes
   if (LANES != 8) begin : g_bad_lanes
      $error("amo_lane_flags: LANES must be 8");
   end

   // one sticky flag per lane, set beats clear
   genvar i;
   generate
      for (i = 0; i < LANES; i++) begin : g_lane
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               flags_o[i] <= amo_pkg::LANE_RESET[i];
            end else if (set_i[i]) begin
               flags_o[i] <= 1'b1;
            end else if (clr_i[i] || clr_all_i) begin
               flags_o[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // amo_lane_flags
`default_nettype wire

// ===== rtl/amo_regs.sv
// alarm mask, alarm status, lane fault flags and core 0 offset trim
// What this block does
// - mask bit 5 set keeps the lane FIFO alarm out of the summary
// - mask bit 4 set keeps the serdes PLL alarm out of the summary
// - mask bit 3 set keeps the link alarm out of the summary
// - mask bit 2 set keeps the realignment alarm out of the summary
// - mask bit 0 set keeps the divider mismatch alarm out of the summary
// - alarm mask resets to 0x3F, all alarms masked
// - lane i FIFO overflow or underflow sets lane flag bit i
// - writing one clears a lane flag; persisting fault sets it again
// - writing one to aggregate FIFO alarm clears all lane flags
// - lane flag register resets to 0xFF
// - 12-bit unsigned offset drives core 0, resets zero, trim overwrites
// - summary alarm is one when any unmasked implemented status bit (5, 4, 3, 2 or 0) is set
// - aggregate FIFO alarm sets on any lane fault, clears on write one
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module amo_regs #(
   parameter int LANES = 8
) (
   input  wire logic                          ref_clk,       // 20 MHz clock
   input  wire logic                          resetn,        // async reset, active low
   input  wire logic [9:0]                    reg_addr,      // register address
   input  wire logic [7:0]                    reg_wdata,     // write data
   input  wire logic                          reg_wr,        // write strobe
   input  wire logic                          reg_rd,        // read strobe
   output logic      [7:0]                    reg_rdata,     // read data, next cycle
   input  wire logic [LANES-1:0]              lane_fifo_err, // lane fifo faults, async
   input  wire logic                          serdes_unlock, // serdes pll not locked, async
   input  wire logic                          link_fault,    // link not in data state, async
   input  wire logic                          clk_realign,   // clocks realigned, async
   input  wire logic                          div_mismatch,  // divider mismatch, async
   input  wire logic                          trim_load,     // factory trim load pulse
   input  wire logic [amo_pkg::TRIM_W-1:0]    trim_value,    // factory trim value
   output logic      [amo_pkg::TRIM_W-1:0]    core0_offset,  // offset applied to core 0
   output logic                               alarm_summary  // summary alarm level
);
   // elaboration check: the register holds exactly eight lanes
   if (LANES != 8) begin : g_bad_lanes
      $error("amo_regs: LANES must be 8");
   end

   amo_pkg::amo_req_s req;
   amo_pkg::amo_evt_s evt_s1_q;
   amo_pkg::amo_evt_s evt_q;
   logic [7:0]  mask_q;
   logic [7:0]  status_q;
   logic [15:0] trim_q;
   logic [7:0]  lane_flags;
   logic [7:0]  lane_clr;
   logic        fifo_clr;
   logic [7:0]  status_set;
   logic [7:0]  status_clr;
   logic [7:0]  rdata_d;
   logic        wr_status;

   // bundle bus signals
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // two-stage synchroniser for event pins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         evt_s1_q <= '0;
         evt_q    <= '0;
      end else begin
         evt_s1_q <= '{lane_fifo_err: lane_fifo_err,
                       serdes_unlock: serdes_unlock, link_fault: link_fault,
                       clk_realign: clk_realign, div_mismatch: div_mismatch};
         evt_q    <= evt_s1_q;
      end
   end

   // alarm mask register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mask_q <= amo_pkg::MASK_RESET;
      end else if (req.wr && req.addr == amo_pkg::ADDR_SOURCE_MASK) begin
         mask_q <= req.wdata;
      end
   end

   // status set and write-one-to-clear terms
   assign wr_status = req.wr && req.addr == amo_pkg::ADDR_ALARM_STATUS;
   assign status_clr = wr_status ? (req.wdata & amo_pkg::STATUS_LIVE) : 8'h00;
   always_comb begin
      status_set = 8'h00;
      status_set[amo_pkg::BIT_FIFO]    = |evt_q.lane_fifo_err;
      status_set[amo_pkg::BIT_SPLL]    = evt_q.serdes_unlock;
      status_set[amo_pkg::BIT_LINK]    = evt_q.link_fault;
      status_set[amo_pkg::BIT_REALIGN] = evt_q.clk_realign;
      status_set[amo_pkg::BIT_CLKDIV]  = evt_q.div_mismatch;
   end

   // alarm status register, set wins over clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= amo_pkg::STATUS_RESET;
      end else begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   // summary alarm from unmasked status bits
   assign alarm_summary = |(status_q & ~mask_q & amo_pkg::STATUS_LIVE);

   // lane flag clear controls
   assign lane_clr = (req.wr && req.addr == amo_pkg::ADDR_LANE_FAULT) ? req.wdata : 8'h00;
   assign fifo_clr = wr_status && req.wdata[amo_pkg::BIT_FIFO];

   amo_lane_flags #(
      .LANES (LANES)
   ) u_lane_flags (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .set_i     (evt_q.lane_fifo_err),
      .clr_i     (lane_clr),
      .clr_all_i (fifo_clr),
      .flags_o   (lane_flags)
   );

   // core 0 offset trim, two byte lanes, factory trim overrides
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         trim_q <= amo_pkg::TRIM_RESET;
      end else if (trim_load) begin
         trim_q <= {4'h0, trim_value};
      end else if (req.wr && req.addr == amo_pkg::ADDR_CORE0_TRIM_LO) begin
         trim_q[7:0] <= req.wdata;
      end else if (req.wr && req.addr == amo_pkg::ADDR_CORE0_TRIM_HI) begin
         trim_q[15:8] <= req.wdata;
      end
   end

   // unsigned offset to core 0
   assign core0_offset = trim_q[amo_pkg::TRIM_W-1:0];

   // read mux
   always_comb begin
      case (req.addr)
         amo_pkg::ADDR_ALARM_SUMMARY: rdata_d = {7'h00, alarm_summary};
         amo_pkg::ADDR_ALARM_STATUS:  rdata_d = status_q;
         amo_pkg::ADDR_SOURCE_MASK:   rdata_d = mask_q;
         amo_pkg::ADDR_LANE_FAULT:    rdata_d = lane_flags;
         amo_pkg::ADDR_CORE0_TRIM_LO: rdata_d = trim_q[7:0];
         amo_pkg::ADDR_CORE0_TRIM_HI: rdata_d = trim_q[15:8];
         default:                     rdata_d = 8'h00;
      endcase
   end

   // read data register, valid the cycle after the read strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (req.rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // amo_regs
`default_nettype wire

// ===== tb/amo_regs_sva.sv
// assertions on the ports of the alarm mask and offset register bank
`timescale 1ns/1ns
`default_nettype none
module amo_regs_sva #(
   parameter int LANES = 8
) (
   input wire logic                       ref_clk,       // clock
   input wire logic                       resetn,        // reset, active low
   input wire logic [9:0]                 reg_addr,      // address
   input wire logic [7:0]                 reg_wdata,     // write data
   input wire logic                       reg_wr,        // write strobe
   input wire logic                       reg_rd,        // read strobe
   input wire logic [7:0]                 reg_rdata,     // read data
   input wire logic [LANES-1:0]           lane_fifo_err, // lane faults
   input wire logic                       trim_load,     // trim load pulse
   input wire logic [amo_pkg::TRIM_W-1:0] trim_value,    // trim value
   input wire logic [amo_pkg::TRIM_W-1:0] core0_offset,  // applied offset
   input wire logic                       alarm_summary  // summary alarm
);
   // one domain for every check
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_trim_load: assert property (trim_load |=> core0_offset == $past(trim_value))
      else $error("offset not loaded from trim");
   a_offset_hold: assert property (!trim_load && !(reg_wr && reg_addr[9:1] == 9'h198)
      |=> $stable(core0_offset)) else $error("offset moved without cause");
   a_trim_lo_wr: assert property (reg_wr && reg_addr == 10'h330 && !trim_load
      |=> core0_offset[7:0] == $past(reg_wdata)) else $error("offset low byte wrong");
   a_trim_hi_wr: assert property (reg_wr && reg_addr == 10'h331 && !trim_load
      |=> core0_offset[11:8] == $past(reg_wdata[3:0])) else $error("offset high bits wrong");
   a_all_masked: assert property (reg_wr && reg_addr == 10'h2C2 && reg_wdata[5:0] == 6'h3F
      |=> !alarm_summary) else $error("summary high with all masked");
   a_mask_read: assert property (reg_wr && reg_addr == 10'h2C2 ##1 reg_rd && reg_addr == 10'h2C2
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("mask readback wrong");
   a_lane_sets: assert property ($stable(lane_fifo_err) [*5] ##0 reg_rd && reg_addr == 10'h2C4
      |=> (reg_rdata & $past(lane_fifo_err)) == $past(lane_fifo_err)) else $error("lane flag missing");
   a_lane_clear: assert property ($stable(lane_fifo_err) [*4] ##0 lane_fifo_err == '0 && reg_wr
      && reg_addr == 10'h2C4 && reg_wdata == 8'hFF ##1 reg_rd && reg_addr == 10'h2C4
      |=> reg_rdata == 8'h00) else $error("lane flags not cleared");
endmodule // amo_regs_sva
bind amo_regs amo_regs_sva #(.LANES(LANES)) amo_regs_sva_i (.ref_clk, .resetn, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_fifo_err, .trim_load, .trim_value,
   .core0_offset, .alarm_summary);
`default_nettype wire

// ===== tb/tb_amo_regs.sv
// self-checking bench for the alarm mask and offset register bank
`timescale 1ns/1ns
`default_nettype none
module tb_amo_regs;
   logic        ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, trim_load = 0, rd_seen = 0;
   logic        serdes_unlock = 0, link_fault = 0, clk_realign = 0, div_mismatch = 0;
   logic [9:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0, lane_fifo_err = 0, reg_rdata, r;
   logic [11:0] trim_value = 0, core0_offset, d;
   logic        alarm_summary;
   logic [7:0]  exp_q[$];
   integer      bad_count = 0, check_count = 0, seed = 32'hBEDC07C2, b;
   amo_regs amo_regs_i (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .lane_fifo_err, .serdes_unlock, .link_fault, .clk_realign, .div_mismatch, .trim_load,
      .trim_value, .core0_offset, .alarm_summary);
   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   task automatic check(input logic [11:0] s, e, input string n);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, rr, input logic [9:0] a, input logic [7:0] v);
      reg_wr <= w;
      reg_rd <= rr;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(0, 1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(0, 0, 10'h000, 8'h00);
   endtask
   task automatic alm(input logic [5:0] v);
      lane_fifo_err <= {7'h00, v[5]};
      serdes_unlock <= v[4];
      link_fault <= v[3];
      clk_realign <= v[2];
      div_mismatch <= v[0];
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // compare each read answer with the oldest note
   always @(posedge ref_clk) begin
      if (rd_seen) check({4'h0, reg_rdata}, {4'h0, exp_q.pop_front()}, "read data");
      rd_seen <= reg_rd;
   end
   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1;
      rd(10'h2C2, 8'h3F);
      rd(10'h2C4, 8'hFF);
      rd(10'h330, 8'h00);
      rd(10'h3FF, 8'h00);
      rd(10'h2C1, 8'h3F);
      rd(10'h2C0, 8'h00);
      #1 check(core0_offset, 12'h000, "offset reset");
      check({11'h0, alarm_summary}, 12'h000, "summary reset");
      bus(1, 0, 10'h2C4, 8'h0F);
      bus(1, 0, 10'h2C4, 8'h00);
      rd(10'h2C4, 8'hF0);
      bus(1, 0, 10'h2C1, 8'h20);
      rd(10'h2C4, 8'h00);
      r = 8'($random(seed));
      lane_fifo_err <= r;
      idle(5);
      rd(10'h2C4, r);
      lane_fifo_err <= 8'h08;
      idle(5);
      bus(1, 0, 10'h2C4, 8'hFF);
      rd(10'h2C4, 8'h08);
      alm(6'h00);
      idle(4);
      bus(1, 0, 10'h2C4, 8'hFF);
      rd(10'h2C4, 8'h00);
      bus(1, 0, 10'h2C1, 8'h3D);
      rd(10'h2C1, 8'h02);
      for (b = 0; b < 6; b++) begin
         if (b == 1) continue;
         bus(1, 0, 10'h2C2, 8'h3F & ~(8'h01 << b));
         rd(10'h2C2, 8'h3F & ~(8'h01 << b));
         #1 check({11'h0, alarm_summary}, 12'h000, "summary quiet");
         alm(6'h01 << b);
         idle(5);
         #1 check({11'h0, alarm_summary}, 12'h001, "summary raised");
         rd(10'h2C0, 8'h01);
         bus(1, 0, 10'h2C2, 8'h3F);
         #1 check({11'h0, alarm_summary}, 12'h000, "summary masked");
         alm(6'h00);
         idle(4);
         bus(1, 0, 10'h2C1, 8'h01 << b);
      end
      d = 12'($random(seed));
      // calibration never runs here, so offsets may be touched at any time
      bus(1, 0, 10'h330, d[7:0]);
      bus(1, 0, 10'h331, {4'h0, d[11:8]});
      rd(10'h330, d[7:0]);
      rd(10'h331, {4'h0, d[11:8]});
      #1 check(core0_offset, d, "offset");
      trim_value <= ~d;
      trim_load <= 1;
      bus(1, 0, 10'h330, 8'hA5);
      trim_load <= 0;
      rd(10'h331, {4'h0, ~d[11:8]});
      #1 check(core0_offset, ~d, "trim");
      idle(2);
      check(12'(exp_q.size()), 12'h000, "reads unanswered");
      stop_test();
   end
endmodule // tb_amo_regs
`default_nettype wire
